// File: rtl/lsa_unit.sv
// load/store align unit: address, lanes, extension, merge, link flag
//
// What this block does
// - address is base plus sign-extended offset
// - signed byte load sign-extends into target
// - unsigned byte load zero-fills upper bits
// - signed halfword load replicates top bit
// - unsigned halfword load clears upper bits
// - word load sign-extends in 64-bit mode
// - unsigned word load clears upper half
// - word-left load merges, addressed byte high
// - word-right load merges, addressed byte low
// - byte store writes only low byte
// - halfword store writes only low halfword
// - word store writes only low word
// - word-left store shifts right, writes lower part
// - word-right store shifts left, writes upper part
// - doubleword load passes data unchanged
// - dword-left load merges, addressed byte high
// - dword-right load merges, addressed byte low
// - linked loads set the reservation flag
// - flag cleared by return or invalidation
// - conditional store writes only when flag set
// - lanes from size, address bits, byte order
// - bad alignment raises address error, no access
//
// operation overview
// - one request at a time; reqReady is high only while idle
// - the effective address and lane mask are formed combinationally
// - the request is captured into state on the taking edge
// - misaligned requests never reach memory; addrError pulses instead
// - a failed conditional store answers at once with a zero result
// - every other request raises memReq for exactly one cycle
// - memAddr, memByteEn and memWdata stand until the next request
// - the answer is taken on the edge that samples memAck high
// - resValid rises on that edge and pulses for one cycle with the shaped data
// - loads always write the target; stores only when conditional
// - the reservation flag is set by a finishing linked load
// - return or invalidation clears it unless a linked load ends together
// - the set wins so a reservation is never lost to a racing clear
//
// byte order
// - store data is replicated over all lanes so memory picks it by mask
// - lanes count from the lowest byte address in little endian
// - big endian mirrors the lane index within the doubleword
// - word halves are chosen by address bit 2 and the byte order
// - split stores are shifted into lane order, so no byte swap is needed
//
// limitations
// - no back-to-back requests: the next is taken after resValid
// - no doubleword store forms; the op table holds stores up to word size only
// - the memory must answer every access exactly once
// - a memory that never answers leaves the unit waiting for good
// - badAddr reports the doubleword-aligned form of the address
// - byte order and mode are read again when the answer arrives,
//   so they must not change while an access is outstanding
// - the lane mask of a split form covers its whole containing unit;
//   the split store narrows it further by its own byte enables
`timescale 1ns/1ps
module lsa_unit
  import lsa_pkg::*;
#(
  parameter int unsigned DW = LSA_XLEN
)(
  input  wire logic          ref_clk,
  input  wire logic          resetn,
  input  wire logic          reqValid,      // one-cycle request strobe
  input  wire logic [4:0]    reqOp,         // lsa_op_t code
  input  wire logic [DW-1:0] baseVal,       // base register contents
  input  wire logic [15:0]   offsetVal,     // instruction offset field
  input  wire logic [DW-1:0] targetIn,      // current target_register value
  input  wire logic          bigEndian,     // configured byte order
  input  wire logic          mode64,        // 64-bit mode
  input  wire logic          exceptionReturn, // exception_return executed
  input  wire logic          cacheInval,    // cache invalidation of the line
  output logic               reqReady,      // idle, request may be taken
  output logic               memReq,        // memory access strobe
  output logic               memWrite,      // access is a store
  output logic [DW-1:0]      memAddr,       // doubleword-aligned address
  output logic [7:0]         memByteEn,     // byte lanes written or read
  output logic [DW-1:0]      memWdata,      // store data in lane position
  input  wire logic          memAck,        // memory answer strobe
  input  wire logic [DW-1:0] memRdata,      // doubleword read data
  output logic               resValid,      // result strobe
  output logic [DW-1:0]      resData,       // new target_register value
  output logic               resWrite,      // target_register is written
  output logic               addrError,     // address error exception pulse
  output logic [DW-1:0]      badAddr,       // doubleword-aligned faulting address
  output logic               linkFlag       // link_reservation_flag
);
  // one packed struct keeps reset and update of all state in one place
  // all state of the module
  typedef struct packed {
    lsa_state_t  st;
    logic [4:0]  op;
    logic [2:0]  lo;
    logic [DW-1:0] tgt;
    logic [DW-1:0] addr;
    logic [7:0]  be;
    logic [DW-1:0] wd;
    logic        wr;
    logic        req;
    logic        rv;
    logic [DW-1:0] rd;
    logic        rw;
    logic        ae;
    logic        llf;
  } lsa_reg_t;

  lsa_reg_t    s_ff;       // registered state
  lsa_reg_t    nxt_s;      // next state
  logic [DW-1:0] effAddr;  // effective address
  logic [7:0]  laneMask;   // lanes of the request
  logic        alignErr;   // illegal size/alignment pair

  // the adder is combinational; its result is only used on the taking edge
  // a carry out of bit 63 is dropped, addresses wrap around
  lsa_addr_gen u_addr (
    .baseVal   (baseVal),
    .offsetVal (offsetVal),
    .effAddr   (effAddr)
  );

  // lanes and alignment follow the live request, not the stored one
  // the stored low address bits are used later for load shaping
  lsa_lane_sel u_lane (
    .opCode    (reqOp),
    .addrLow   (effAddr[2:0]),
    .bigEndian (bigEndian),
    .laneMask  (laneMask),
    .alignErr  (alignErr)
  );

  // load data shaping: extract, extend or merge
  function automatic logic [DW-1:0] shape_load(input logic [4:0] op, input logic [2:0] lo,
                                               input logic be, input logic m64,
                                               input logic [DW-1:0] rd, input logic [DW-1:0] t);
    logic [2:0]  b;
    logic [5:0]  sh;
    logic [31:0] w;
    logic [31:0] wm;
    logic [31:0] tw;
    logic [DW-1:0] dm;
    logic [DW-1:0] r;
    logic [1:0]  k;
    logic [2:0]  kd;
    // b: lane index of the addressed byte counted from bit 0
    // sh: bit position of that lane
    // w: the word half that holds the addressed word
    b  = be ? ~lo : lo;
    sh = {b, 3'b000};
    w  = lo[2] ^ be ? rd[63:32] : rd[31:0];
    wm = 32'h0;
    tw = t[31:0];
    dm = 64'h0;
    r  = t;
    // k: byte offset inside the word from its most significant end
    k  = be ? lo[1:0] : ~lo[1:0];
    kd = be ? lo : ~lo;
    // sized loads pick their lanes and extend
    // split forms shift the fetched unit and keep the untouched target bytes
    // in 32-bit mode signed, linked and split word loads leave the upper half of the target as it was
    // anything else leaves the target unchanged
    case (op)
      LSA_LD_BYTE_S: r = {{56{rd[sh+7]}}, rd[sh +: 8]};
      LSA_LD_BYTE_U: r = {56'h0, rd[sh +: 8]};
      LSA_LD_HALF_S: r = {{48{rd[{b[2:1], 4'h0}+15]}}, rd[{b[2:1], 4'h0} +: 16]};
      LSA_LD_HALF_U: r = {48'h0, rd[{b[2:1], 4'h0} +: 16]};
      LSA_LD_WORD_S, LSA_LD_LINK_W: begin
        r = m64 ? {{32{w[31]}}, w} : {t[63:32], w};
      end
      LSA_LD_WORD_U: r = {32'h0, w};
      // left: addressed byte moves to the top of the word
      // the bytes below it come from the old target
      LSA_LD_WORD_L: begin
        wm = (w << {k, 3'b000}) | (tw & ~(32'hFFFFFFFF << {k, 3'b000}));
        r  = m64 ? {{32{wm[31]}}, wm} : {t[63:32], wm};
      end
      // right: addressed byte moves to the bottom of the word
      // the bytes above it come from the old target
      LSA_LD_WORD_R: begin
        wm = (w >> {~k, 3'b000}) | (tw & ~(32'hFFFFFFFF >> {~k, 3'b000}));
        r  = m64 ? {{32{wm[31]}}, wm} : {t[63:32], wm};
      end
      LSA_LD_DWORD, LSA_LD_LINK_D: r = rd;
      // same merge as the word form, over the whole doubleword
      LSA_LD_DWORD_L: begin
        dm = (rd << {kd, 3'b000}) | (t & ~(64'hFFFFFFFFFFFFFFFF << {kd, 3'b000}));
        r  = dm;
      end
      // no sign extension is needed: all 64 bits are defined
      LSA_LD_DWORD_R: begin
        dm = (rd >> {~kd, 3'b000}) | (t & ~(64'hFFFFFFFFFFFFFFFF >> {~kd, 3'b000}));
        r  = dm;
      end
      default: r = t;
    endcase
    return r;
  endfunction

  // controller and datapath next state
  always_comb begin
    logic [1:0]  kk;
    logic [31:0] sw;
    logic [3:0]  wbe;
    logic        isSt;
    logic        isCond;
    kk     = 2'h0;
    sw     = 32'h0;
    wbe    = 4'h0;
    // stores have the top op bit set
    isSt   = reqOp[4];
    isCond = (reqOp == LSA_ST_COND);
    nxt_s  = s_ff;
    // every strobe defaults low so each pulse lasts one cycle
    nxt_s.rv  = 1'b0;
    nxt_s.ae  = 1'b0;
    nxt_s.req = 1'b0;
    // invalidation or return drops the reservation; a linked load finishing later re-sets it
    if (exceptionReturn || cacheInval) begin
      nxt_s.llf = 1'b0;
    end
    case (s_ff.st)
      // idle: take a request and decide between fault, quick answer and access
      // the target value is captured now because the merge needs it later
      // requests seen in any other state are ignored
      LSA_IDLE: begin
        if (reqValid) begin
          nxt_s.op   = reqOp;
          nxt_s.lo   = effAddr[2:0];
          nxt_s.tgt  = targetIn;
          nxt_s.addr = {effAddr[DW-1:3], 3'b000};
          nxt_s.wr   = isSt;
          kk = bigEndian ? effAddr[1:0] : ~effAddr[1:0];
          case (reqOp)
            LSA_ST_WORD_L: begin
              sw  = targetIn[31:0] >> {kk, 3'b000};
              wbe = 4'hF >> kk;
            end
            LSA_ST_WORD_R: begin
              sw  = targetIn[31:0] << {~kk, 3'b000};
              wbe = 4'hF << ~kk;
            end
            default: begin
              sw  = targetIn[31:0];
              wbe = 4'hF;
            end
          endcase
          // a fault has priority over everything, so no access is ever made
          // a failed conditional store needs no memory and answers at once
          // otherwise the access is issued on the next cycle
          if (alignErr) begin
            nxt_s.ae = 1'b1;
            nxt_s.st = LSA_DONE;
            nxt_s.rw = 1'b0;
          end else if (isCond && !s_ff.llf) begin
            nxt_s.rd = LSA_DATA_RST;
            nxt_s.rw = 1'b1;
            nxt_s.rv = 1'b1;
          end else begin
            nxt_s.req = 1'b1;
            nxt_s.st  = LSA_WAIT;
            case (reqOp)
              LSA_ST_BYTE: begin
                nxt_s.wd = {8{targetIn[7:0]}};
                nxt_s.be = laneMask;
              end
              LSA_ST_HALF: begin
                nxt_s.wd = {4{targetIn[15:0]}};
                nxt_s.be = laneMask;
              end
              LSA_ST_WORD, LSA_ST_COND: begin
                nxt_s.wd = {2{targetIn[31:0]}};
                nxt_s.be = laneMask;
              end
              LSA_ST_WORD_L, LSA_ST_WORD_R: begin
                // the shift already puts bytes in lane order for either byte order
                nxt_s.wd = {2{sw}};
                nxt_s.be = {wbe, wbe} & laneMask;
              end
              default: begin
                nxt_s.wd = LSA_DATA_RST;
                nxt_s.be = laneMask;
              end
            endcase
          end
        end
      end
      // wait: the access is out; the answer edge ends it
      // read data is only valid on that edge, so it is shaped at once
      // the store result is one for every store but is written only for a conditional store
      LSA_WAIT: begin
        if (memAck) begin
          nxt_s.st = LSA_IDLE;
          nxt_s.rv = 1'b1;
          if (s_ff.wr) begin
            nxt_s.rw = (s_ff.op == LSA_ST_COND);
            nxt_s.rd = 64'h1;
          end else begin
            nxt_s.rw = 1'b1;
            nxt_s.rd = shape_load(s_ff.op, s_ff.lo, bigEndian, mode64, memRdata, s_ff.tgt);
            if (s_ff.op == LSA_LD_LINK_W || s_ff.op == LSA_LD_LINK_D) begin
              nxt_s.llf = 1'b1;
            end
          end
        end
      end
      // done: one cycle of rest after a fault
      // keeps the fault pulse apart from the next request
      LSA_DONE: begin
        nxt_s.st = LSA_IDLE;
      end
      default: begin
        nxt_s.st = LSA_IDLE;
      end
    endcase
  end

  // reset assigns constants only; the whole struct updates on every edge
  // no clock enable: idle cycles simply reload the same values
  // state register
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      s_ff <= '{st: LSA_IDLE, op: 5'h00, lo: 3'h0, tgt: LSA_DATA_RST, addr: LSA_DATA_RST,
                be: LSA_MASK_RST, wd: LSA_DATA_RST, wr: 1'b0, req: 1'b0, rv: 1'b0,
                rd: LSA_DATA_RST, rw: 1'b0, ae: 1'b0, llf: LSA_LLF_RST};
    end else begin
      s_ff <= nxt_s;
    end
  end

  // every data output comes from a flip-flop; reqReady is the only decode
  // the memory side sees stable values for the whole access
  // outputs straight from state
  assign reqReady  = (s_ff.st == LSA_IDLE);
  assign memReq    = s_ff.req;
  assign memWrite  = s_ff.wr;
  assign memAddr   = s_ff.addr;
  assign memByteEn = s_ff.be;
  assign memWdata  = s_ff.wd;
  assign resValid  = s_ff.rv;
  assign resData   = s_ff.rd;
  assign resWrite  = s_ff.rw;
  assign addrError = s_ff.ae;
  assign badAddr   = s_ff.addr;
  assign linkFlag  = s_ff.llf;
endmodule

// File: rtl/lsa_pkg.sv
// shared constants and types of the load/store align unit
package lsa_pkg;
  localparam int unsigned LSA_XLEN     = 64;
  localparam int unsigned LSA_OFS_W    = 16;
  localparam int unsigned LSA_LANES    = 8;
  localparam logic        LSA_LLF_RST  = 1'b0;
  localparam logic [63:0] LSA_DATA_RST = 64'h0;
  localparam logic [7:0]  LSA_MASK_RST = 8'h00;
  localparam int unsigned LSA_RESP_CYC = 1;
  // operation codes, one per access kind
  typedef enum logic [4:0] {
    LSA_LD_BYTE_S  = 5'h00,
    LSA_LD_BYTE_U  = 5'h01,
    LSA_LD_HALF_S  = 5'h02,
    LSA_LD_HALF_U  = 5'h03,
    LSA_LD_WORD_S  = 5'h04,
    LSA_LD_WORD_U  = 5'h05,
    LSA_LD_WORD_L  = 5'h06,
    LSA_LD_WORD_R  = 5'h07,
    LSA_LD_DWORD   = 5'h08,
    LSA_LD_DWORD_L = 5'h09,
    LSA_LD_DWORD_R = 5'h0A,
    LSA_LD_LINK_W  = 5'h0B,
    LSA_LD_LINK_D  = 5'h0C,
    LSA_ST_BYTE    = 5'h10,
    LSA_ST_HALF    = 5'h11,
    LSA_ST_WORD    = 5'h12,
    LSA_ST_WORD_L  = 5'h13,
    LSA_ST_WORD_R  = 5'h14,
    LSA_ST_COND    = 5'h15
  } lsa_op_t;
  // controller states, one-hot
  typedef enum logic [2:0] {
    LSA_IDLE = 3'b001,
    LSA_WAIT = 3'b010,
    LSA_DONE = 3'b100
  } lsa_state_t;
endpackage

// File: rtl/lsa_addr_gen.sv
// effective address adder: base plus sign-extended offset
`timescale 1ns/1ps
module lsa_addr_gen
  import lsa_pkg::*;
(
  input  wire logic [63:0] baseVal,
  input  wire logic [15:0] offsetVal,
  output logic      [63:0] effAddr
);
  // sign-extend the offset, then add; carry out is dropped by width
  always_comb begin
    effAddr = baseVal + {{(LSA_XLEN-LSA_OFS_W){offsetVal[15]}}, offsetVal};
  end
endmodule

// File: rtl/lsa_lane_sel.sv
// byte-lane selector and alignment checker within a doubleword
`timescale 1ns/1ps
module lsa_lane_sel
  import lsa_pkg::*;
(
  input  wire logic [4:0] opCode,
  input  wire logic [2:0] addrLow,
  input  wire logic       bigEndian,
  output logic      [7:0] laneMask,
  output logic            alignErr
);
  logic [2:0] b;  // lane index counted from bit 0, mirrored from the address in big endian
  // lanes follow size, low address bits and byte order
  always_comb begin
    b        = bigEndian ? ~addrLow : addrLow;
    laneMask = 8'h00;
    alignErr = 1'b0;
    case (opCode)
      LSA_LD_BYTE_S, LSA_LD_BYTE_U, LSA_ST_BYTE: begin
        laneMask = 8'h01 << b;
      end
      LSA_LD_HALF_S, LSA_LD_HALF_U, LSA_ST_HALF: begin
        alignErr = addrLow[0];
        laneMask = 8'h03 << {b[2:1], 1'b0};
      end
      LSA_LD_WORD_S, LSA_LD_WORD_U, LSA_ST_WORD, LSA_LD_LINK_W, LSA_ST_COND: begin
        alignErr = |addrLow[1:0];
        laneMask = 8'h0F << {b[2], 2'b00};
      end
      LSA_LD_DWORD, LSA_LD_LINK_D: begin
        alignErr = |addrLow;
        laneMask = 8'hFF;
      end
      // unaligned forms fetch the whole containing unit
      LSA_LD_WORD_L, LSA_LD_WORD_R, LSA_ST_WORD_L, LSA_ST_WORD_R: begin
        laneMask = 8'h0F << {b[2], 2'b00};
      end
      LSA_LD_DWORD_L, LSA_LD_DWORD_R: begin
        laneMask = 8'hFF;
      end
      default: begin
        alignErr = 1'b1;
      end
    endcase
  end
endmodule

// File: verif/lsa_mem_model.sv
// memory-side model: answers each access after a bench-chosen delay
`timescale 1ns/1ps
module lsa_mem_model (
  input  wire logic        ref_clk,
  input  wire logic        memReq,
  input  wire logic [63:0] memAddr,
  input  wire logic [1:0]  ackDelay,
  output logic             memAck,
  output logic [63:0]      memRdata
);
  logic [1:0] waitCnt = 2'h0; // cycles left before the answer
  logic       busy    = 1'b0; // an access is outstanding
  // read pattern derived from the doubleword address
  function automatic logic [63:0] pat(input logic [63:0] a);
    return {a[31:0] ^ 32'h9E37_79B9, a[63:32] + 32'h7F4A_7C15};
  endfunction
  initial begin
    memAck = 1'b0;
    memRdata = 64'h0;
  end
  // one access at a time; data lines toggle when not answering so a stale value never passes
  always @(posedge ref_clk) begin
    memAck <= 1'b0;
    memRdata <= ~memRdata;
    if (memReq) begin
      busy <= 1'b1;
      waitCnt <= ackDelay;
    end else if (busy && waitCnt == 2'h0) begin
      memAck <= 1'b1;
      memRdata <= pat(memAddr);
      busy <= 1'b0;
    end else if (busy) begin
      waitCnt <= waitCnt - 2'h1;
    end
  end
endmodule

// File: verif/lsa_unit_asserts.sv
// port assertions of the load/store align unit
`timescale 1ns/1ps
module lsa_unit_asserts
  import lsa_pkg::*;
#(
  parameter int unsigned DW = 64
)(
  input wire logic          ref_clk,
  input wire logic          resetn,
  input wire logic          reqValid,
  input wire logic [4:0]    reqOp,
  input wire logic [DW-1:0] baseVal,
  input wire logic [15:0]   offsetVal,
  input wire logic          exceptionReturn,
  input wire logic          cacheInval,
  input wire logic          reqReady,
  input wire logic          memReq,
  input wire logic          memWrite,
  input wire logic [DW-1:0] memAddr,
  input wire logic          memAck,
  input wire logic [DW-1:0] memRdata,
  input wire logic          resValid,
  input wire logic [DW-1:0] resData,
  input wire logic          addrError,
  input wire logic          linkFlag
);
  logic [4:0]    opFf; // op of the request in flight
  logic [DW-1:0] eaFf; // its effective address
  wire  logic    take = reqValid && reqReady;
  // capture each request so later answers can be tied to it
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      opFf <= 5'h00;
      eaFf <= '0;
    end else if (take) begin
      opFf <= reqOp;
      eaFf <= baseVal + DW'({{48{offsetVal[15]}}, offsetVal});
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  a_addr_from_base: assert property (memReq |-> memAddr == {eaFf[DW-1:3], 3'h0}) else $error("bad address");
  a_take_answered: assert property (take |=> memReq || addrError || resValid) else $error("no answer");
  a_err_no_access: assert property (addrError |-> !memReq) else $error("access on fault");
  a_dword_pass: assert property (memAck && !reqReady && opFf == LSA_LD_DWORD |=> resData == $past(memRdata))
    else $error("dword altered");
  a_byte_zero: assert property (memAck && !reqReady && opFf == LSA_LD_BYTE_U |=> resData[63:8] == 56'h0)
    else $error("byte not zero filled");
  a_half_zero: assert property (memAck && !reqReady && opFf == LSA_LD_HALF_U |=> resData[63:16] == 48'h0)
    else $error("half not zero filled");
  a_word_zero: assert property (memAck && !reqReady && opFf == LSA_LD_WORD_U |=> resData[63:32] == 32'h0)
    else $error("word not zero filled");
  a_link_set: assert property (memAck && !reqReady && opFf inside {LSA_LD_LINK_W, LSA_LD_LINK_D} |=> linkFlag)
    else $error("link flag not set");
  a_link_clear: assert property ((exceptionReturn || cacheInval) && !(memAck && !reqReady) |=> !linkFlag)
    else $error("link flag not cleared");
  a_cond_fail: assert property (take && reqOp == LSA_ST_COND && !linkFlag
    && baseVal[1:0] + offsetVal[1:0] == 2'h0 |=> resValid && !memReq && resData == '0)
    else $error("failed store wrote");
  a_cond_pass: assert property (take && reqOp == LSA_ST_COND && linkFlag && !exceptionReturn && !cacheInval
    && baseVal[1:0] + offsetVal[1:0] == 2'h0 |=> memReq && memWrite) else $error("store skipped");
endmodule
bind lsa_unit lsa_unit_asserts #(.DW(DW)) lsa_unit_asserts_inst (.ref_clk, .resetn, .reqValid, .reqOp, .baseVal,
  .offsetVal, .exceptionReturn, .cacheInval, .reqReady, .memReq, .memWrite, .memAddr, .memAck, .memRdata,
  .resValid, .resData, .addrError, .linkFlag);

// File: verif/testbench.sv
// self-checking bench of the load/store align unit
`timescale 1ns/1ps
module testbench;
  import lsa_pkg::*;
  logic        ref_clk, resetn, reqValid, bigEndian, mode64, exceptionReturn, cacheInval, linkExp;
  logic [4:0]  reqOp;
  logic [15:0] offsetVal;
  logic [63:0] baseVal, targetIn, memAddr, memWdata, memRdata, resData, badAddr;
  logic [7:0]  memByteEn;
  logic [1:0]  ackDelay;
  logic        reqReady, memReq, memWrite, memAck, resValid, resWrite, addrError, linkFlag;
  logic [31:0] seed = 32'h0921;
  int          fails = 0;
  int          comparisons = 0;
  lsa_op_t     ops [18] = '{LSA_LD_BYTE_S, LSA_LD_BYTE_U, LSA_LD_HALF_S, LSA_LD_HALF_U, LSA_LD_WORD_S,
    LSA_LD_WORD_U, LSA_LD_WORD_L, LSA_LD_WORD_R, LSA_LD_DWORD, LSA_LD_DWORD_L, LSA_LD_DWORD_R, LSA_LD_LINK_W,
    LSA_LD_LINK_D, LSA_ST_BYTE, LSA_ST_HALF, LSA_ST_WORD, LSA_ST_WORD_L, LSA_ST_WORD_R};
  lsa_unit lsa_unit_inst (.ref_clk, .resetn, .reqValid, .reqOp, .baseVal, .offsetVal, .targetIn, .bigEndian,
    .mode64, .exceptionReturn, .cacheInval, .reqReady, .memReq, .memWrite, .memAddr, .memByteEn, .memWdata,
    .memAck, .memRdata, .resValid, .resData, .resWrite, .addrError, .badAddr, .linkFlag);
  lsa_mem_model lsa_mem_model_inst (.ref_clk, .memReq, .memAddr, .ackDelay, .memAck, .memRdata);
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // access size in bytes; left/right forms are not sized here
  function automatic int sz(logic [4:0] op);
    case (op)
      LSA_LD_BYTE_S, LSA_LD_BYTE_U, LSA_ST_BYTE: return 1;
      LSA_LD_HALF_S, LSA_LD_HALF_U, LSA_ST_HALF: return 2;
      LSA_LD_DWORD, LSA_LD_LINK_D: return 8;
      default: return 4;
    endcase
  endfunction
  task automatic cmp(logic [63:0] got, logic [63:0] exp, string what, logic [63:0] m = '1);
    comparisons++;
    if ((got & m) !== (exp & m)) begin
      fails++;
      $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic print_verdict();
    if (fails == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // one request, then fault, access, lanes, store data, result and link flag checked against the expectation
  task automatic run(lsa_op_t op, logic [63:0] b, logic [15:0] o);
    logic [63:0] ea, m, v, mem, d, mk;
    logic [7:0]  lm, e;
    int          s, k, n, p, q, j, src, w, off;
    logic        lr, mis, bad, sc, st, left;
    repeat (2) @(negedge ref_clk);
    ea = b + {{48{o[15]}}, o};
    s = sz(op);
    k = bigEndian ? 8 - s - int'(ea[2:0]) : int'(ea[2:0]);
    lr = op inside {LSA_LD_WORD_L, LSA_LD_WORD_R, LSA_LD_DWORD_L, LSA_LD_DWORD_R, LSA_ST_WORD_L, LSA_ST_WORD_R};
    sc = op == LSA_ST_COND;
    st = op >= LSA_ST_BYTE;
    mis = !lr && (int'(ea[2:0]) % s) != 0;
    bad = sc && !linkExp && !mis;
    m = (s == 8) ? '1 : (64'h1 << (8 * s)) - 64'h1;
    lm = 8'(((16'h1 << s) - 16'h1) << k);
    reqOp = op;
    baseVal = b;
    offsetVal = o;
    targetIn = {rnd(), rnd()};
    ackDelay = 2'(rnd());
    reqValid = 1'b1;
    @(negedge ref_clk);
    reqValid = 1'b0;
    for (n = 0; n < 20 && resValid !== 1'b1 && addrError !== 1'b1; n++) @(negedge ref_clk);
    cmp(addrError, mis, "address error");
    if (mis || bad) cmp(memReq, 1'b0, "access made");
    if (mis) cmp(badAddr, {ea[63:3], 3'h0}, "bad address");
    else if (bad) cmp(resData, 64'h0, "failed store result");
    else begin
      cmp(resValid, 1'b1, "no result");
      cmp(memAddr, {ea[63:3], 3'h0}, "address");
      cmp(resWrite, !st || sc, "target write");
      if (!lr) cmp(memByteEn, lm, "byte lanes");
      if (st && !lr) cmp(memWdata, targetIn << (8 * k), "store data", m << (8 * k));
      if (sc) cmp(resData, 64'h1, "store result");
      if (!st && !lr) begin
        v = (lsa_mem_model_inst.pat({ea[63:3], 3'h0}) >> (8 * k)) & m;
        if (op inside {LSA_LD_BYTE_S, LSA_LD_HALF_S, LSA_LD_WORD_S} && v[8 * s - 1]) v = v | ~m;
        if (op == LSA_LD_WORD_S && !mode64) v[63:32] = targetIn[63:32];
        cmp(resData, v, "load data", (op == LSA_LD_LINK_W) ? 64'hFFFF_FFFF : '1);
      end
      // split forms: byte by byte from the rules, p is the addressed byte's significance
      if (lr) begin
        q = (op inside {LSA_LD_DWORD_L, LSA_LD_DWORD_R}) ? 8 : 4;
        p = bigEndian ? q - 1 - int'(ea[2:0]) % q : int'(ea[2:0]) % q;
        w = (q == 4 && (ea[2] ^ bigEndian)) ? 32 : 0;
        mem = lsa_mem_model_inst.pat({ea[63:3], 3'h0}) >> w;
        left = op inside {LSA_LD_WORD_L, LSA_LD_DWORD_L, LSA_ST_WORD_L};
        off = left ? q - 1 - p : p;
        {v, d, mk, e} = {targetIn, 64'h0, 64'h0, 8'h00};
        for (j = 0; j < q; j++) begin
          src = (left == st) ? j + off : j - off;
          if (src >= 0 && src < q) begin
            if (st) begin
              e[j + w / 8] = 1'b1;
              mk[8 * (j + w / 8) +: 8] = 8'hFF;
              d[8 * (j + w / 8) +: 8] = targetIn[8 * src +: 8];
            end else begin
              v[8 * j +: 8] = mem[8 * src +: 8];
            end
          end
        end
        if (st) begin
          cmp(memByteEn, e, "split store lanes");
          cmp(memWdata, d, "split store data", mk);
        end else begin
          if (q == 4) v[63:32] = mode64 ? {32{v[31]}} : targetIn[63:32];
          cmp(resData, v, "merged load");
        end
      end
      if (op inside {LSA_LD_LINK_W, LSA_LD_LINK_D}) begin
        linkExp = 1'b1;
        cmp(linkFlag, 1'b1, "link flag");
      end
    end
  endtask
  // exception return or invalidation pulse, then the flag must be clear
  task automatic clr(logic inval);
    @(negedge ref_clk);
    exceptionReturn = !inval;
    cacheInval = inval;
    @(negedge ref_clk);
    exceptionReturn = 1'b0;
    cacheInval = 1'b0;
    linkExp = 1'b0;
    @(negedge ref_clk);
    cmp(linkFlag, 1'b0, "link flag kept");
  endtask
  initial begin
    #100000;
    fails++;
    print_verdict();
  end
  initial begin
    logic [31:0] r;
    logic [63:0] b;
    logic [15:0] o;
    {resetn, reqValid, bigEndian, exceptionReturn, cacheInval, linkExp} = 6'h00;
    mode64 = 1'b1;
    {reqOp, offsetVal, baseVal, targetIn, ackDelay} = '0;
    repeat (20) @(posedge ref_clk);
    @(negedge ref_clk);
    resetn = 1'b1;
    run(LSA_LD_DWORD, 64'h0000_0000_0001_0000, 16'h8000);
    run(LSA_ST_BYTE, 64'hFFFF_FFFF_FFFF_FFFF, 16'h0001);
    clr(1'b0);
    run(LSA_ST_COND, 64'h100, 16'h0);
    run(LSA_LD_LINK_W, 64'h200, 16'h4);
    run(LSA_ST_COND, 64'h200, 16'h8);
    run(LSA_LD_LINK_D, 64'h300, 16'h8);
    clr(1'b1);
    run(LSA_ST_COND, 64'h300, 16'hFFFC);
    for (int i = 0; i < 300; i++) begin
      r = rnd();
      bigEndian = r[0];
      mode64 = r[1];
      b = {rnd(), rnd()};
      o = r[31:16];
      if (r[12]) begin
        b[2:0] = 3'h0;
        o[1:0] = 2'h0;
      end
      run(ops[r[8:4] % 18], b, o);
    end
    print_verdict();
  end
endmodule
